/* hdl/adcoc_top.v */
// digital side of a 10-bit sampling converter: format, clamp, tri-state,
// sleep and nap, stabilizer lock tracking, wishbone control registers
// assumes sample_strobe marks each conversion in the ref_clk domain and
// sample_code arrives as offset binary with over/under flags
`timescale 1ns/1ps
`include "adcoc_regs.vh"
module adcoc_top #(
  parameter SLEEP_CYC = `ADCOC_SLEEP_CYC
) (
  // clock, reset, enable
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        clk_en,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // strap and pins from outside
  input  wire [1:0]  mode_strap,
  input  wire        power_down_pin,
  input  wire        out_ctrl_n_pin,
  // converter core result
  input  wire        sample_strobe,
  input  wire [9:0]  sample_code,
  input  wire        code_over,
  input  wire        code_under,
  input  wire        ext_clk_present,
  // parallel output
  output wire [9:0]  sample_word_o,
  output wire [9:0]  sample_word_oe_n,
  output wire        overrange_flag_o,
  output wire        overrange_flag_oe_n,
  output wire        sample_track,
  output wire        data_valid
);
  // pin synchronisers, two flops each
  reg [1:0] strap_s1_q, strap_s2_q;
  reg       pd_s1_q, pd_s2_q, oe_s1_q, oe_s2_q, clk_s1_q, clk_s2_q;
  // control register
  reg [2:0] ctrl_q;
  // decoded strap
  reg       twos_q, stab_q;
  // power state
  reg [1:0] ps_q;
  reg [31:0] wait_q;
  // stabilizer lock count
  reg [7:0] lock_q;
  reg       locked_q;
  // output pipeline
  reg [9:0] pipe_w_q [0:`ADCOC_PIPE_LAT-1];
  reg [`ADCOC_PIPE_LAT-1:0] pipe_f_q;
  reg [31:0] cnt_q;
  // effective pins: pin or register bit
  wire pd_sel  = pd_s2_q | ctrl_q[`ADCOC_CTRL_PDSEL];
  wire ctl_hi  = oe_s2_q | ctrl_q[`ADCOC_CTRL_OEN];
  wire wb_hit  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire powered = (ps_q == `ADCOC_PS_RUN);
  wire go      = clk_en & sample_strobe & powered &
                 ctrl_q[`ADCOC_CTRL_SAMPEN] & (locked_q | ~stab_q);
  // clamp and format the incoming code
  reg [9:0] fmt_w;
  reg       fmt_f;
  always @* begin
    fmt_f = code_over | code_under; // RQ5
    if (code_over)
      fmt_w = `ADCOC_CODE_TOP; // RQ5 RQ6
    else if (code_under)
      fmt_w = `ADCOC_CODE_BOT; // RQ6
    else
      fmt_w = sample_code;
    if (twos_q)
      fmt_w = {~fmt_w[9], fmt_w[8:0]}; // RQ7
  end
  // synchronise pins and decode strap
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      strap_s1_q <= 2'h0;
      strap_s2_q <= 2'h0;
      pd_s1_q    <= 1'b0;
      pd_s2_q    <= 1'b0;
      oe_s1_q    <= 1'b0;
      oe_s2_q    <= 1'b0;
      clk_s1_q   <= 1'b0;
      clk_s2_q   <= 1'b0;
      twos_q     <= 1'b0;
      stab_q     <= 1'b0;
    end else if (clk_en) begin
      strap_s1_q <= mode_strap;
      strap_s2_q <= strap_s1_q;
      pd_s1_q    <= power_down_pin;
      pd_s2_q    <= pd_s1_q;
      oe_s1_q    <= out_ctrl_n_pin;
      oe_s2_q    <= oe_s1_q;
      clk_s1_q   <= ext_clk_present;
      clk_s2_q   <= clk_s1_q;
      // strap decode
      case (strap_s2_q)
        `ADCOC_MODE_GND:      begin twos_q <= 1'b0; stab_q <= 1'b0; end // RQ8
        `ADCOC_MODE_THIRD:    begin twos_q <= 1'b0; stab_q <= 1'b1; end // RQ8
        `ADCOC_MODE_TWOTHIRD: begin twos_q <= 1'b1; stab_q <= 1'b1; end // RQ8
        default:              begin twos_q <= 1'b1; stab_q <= 1'b0; end // RQ8
      endcase
    end
  end
  // stabilizer relock after clock loss
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      lock_q   <= 8'h00;
      locked_q <= 1'b0;
    end else if (clk_en) begin
      if (!clk_s2_q || !stab_q) begin
        lock_q   <= 8'h00; // clock gone or stabilizer off, start over
        locked_q <= 1'b0;
      end else if (sample_strobe && !locked_q) begin
        if (lock_q == (`ADCOC_RELOCK_CYC - 1))
          locked_q <= 1'b1; // RQ3
        lock_q <= lock_q + 8'h01; // RQ3
      end
    end
  end
  // power state machine
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ps_q   <= `ADCOC_PS_RUN;
      wait_q <= 32'h0;
    end else if (clk_en) begin
      case (ps_q)
        `ADCOC_PS_RUN: begin
          if (pd_sel) // RQ11
            ps_q <= ctl_hi ? `ADCOC_PS_SLEEP : `ADCOC_PS_NAP; // RQ12 RQ13
        end
        `ADCOC_PS_NAP: begin
          if (!pd_sel) begin
            ps_q   <= `ADCOC_PS_WAKE;
            wait_q <= `ADCOC_NAP_CYC - 1; // RQ13
          end else if (ctl_hi)
            ps_q <= `ADCOC_PS_SLEEP; // RQ12
        end
        `ADCOC_PS_SLEEP: begin
          if (!pd_sel) begin
            ps_q   <= `ADCOC_PS_WAKE;
            wait_q <= SLEEP_CYC - 1; // RQ12
          end else if (!ctl_hi)
            ps_q <= `ADCOC_PS_NAP; // RQ13
        end
        `ADCOC_PS_WAKE: begin
          if (pd_sel)
            ps_q <= ctl_hi ? `ADCOC_PS_SLEEP : `ADCOC_PS_NAP;
          else if (wait_q == 32'h0)
            ps_q <= `ADCOC_PS_RUN;
          else
            wait_q <= wait_q - 32'h1;
        end
        default: ps_q <= `ADCOC_PS_RUN;
      endcase
    end
  end
  // output pipeline, one word per sample
  genvar gi;
  generate
    for (gi = 0; gi < `ADCOC_PIPE_LAT; gi = gi + 1) begin : g_pipe
      always @(posedge ref_clk) begin
        if (sys_rst) begin
          pipe_w_q[gi] <= `ADCOC_CODE_MID;
          pipe_f_q[gi] <= 1'b0;
        end else if (go) begin
          pipe_w_q[gi] <= (gi == 0) ? fmt_w : pipe_w_q[(gi == 0) ? 0 : gi-1]; // RQ16
          pipe_f_q[gi] <= (gi == 0) ? fmt_f : pipe_f_q[(gi == 0) ? 0 : gi-1]; // RQ16
        end
      end
    end
  endgenerate
  // sample counter for status
  always @(posedge ref_clk) begin
    if (sys_rst)
      cnt_q <= 32'h0;
    else if (go)
      cnt_q <= cnt_q + 32'h1;
  end
  // wishbone slave, one wait state, ack one cycle
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_q   <= `ADCOC_CTRL_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else if (clk_en) begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= 32'h0;
      // write lands at the edge where the master sees ack high
      if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] &&
          wb_adr_i == `ADCOC_CTRL_ADDR)
        ctrl_q <= wb_dat_i[2:0];
      if (wb_hit) begin
        case (wb_adr_i)
          `ADCOC_CTRL_ADDR:
            wb_dat_o <= {29'h0, ctrl_q};
          `ADCOC_STAT_ADDR:
            wb_dat_o <= {24'h0, locked_q, stab_q, twos_q, ctl_hi,
                         pd_sel, data_valid, ps_q};
          `ADCOC_CNT_ADDR:
            wb_dat_o <= cnt_q;
          default:
            wb_dat_o <= 32'h0; // unmapped reads zero
        endcase
      end
    end
  end
  // tri-state control: enables low while driving
  wire drive = powered & ~ctl_hi; // RQ9 RQ14
  assign data_valid          = drive & (locked_q | ~stab_q);
  assign sample_word_o       = pipe_w_q[`ADCOC_PIPE_LAT-1];
  assign overrange_flag_o    = pipe_f_q[`ADCOC_PIPE_LAT-1];
  assign sample_word_oe_n    = {10{~drive}}; // RQ9 RQ14
  assign overrange_flag_oe_n = ~drive; // RQ9 RQ14
  // tracking phase: low clock without stabilizer
  assign sample_track        = powered & ~stab_q & ~sample_strobe; // RQ15 RQ2
endmodule

/* include/adcoc_regs.vh */
// constants for the converter output and power control block
// assumes a 100 MHz ref_clk and a classic wishbone register slave
// Notes on behaviour
// RQ1: sample clock at most 80Msps, near 50% duty
// RQ2: stabilizer samples rising edge, makes own fall
// RQ3: stabilizer relocks after about hundred clocks
// RQ4: sample rate must stay at least 1Msps
// RQ5: overrange flag set outside full scale, clamp
// RQ6: offset binary codes midscale, top, bottom
// RQ7: twos complement is offset binary, msb inverted
// RQ8: four level strap picks format and stabilizer
// RQ9: output control high floats data and flag
// RQ10: do not toggle output control at speed
// RQ11: power down select low means normal run
// RQ12: select high, control high gives sleep
// RQ13: select high, control low gives nap
// RQ14: sleep and nap float all digital outputs
// RQ15: no stabilizer: track on fall, hold rise
// RQ16: one word per clock, fixed pipeline latency
`ifndef ADCOC_REGS_VH
`define ADCOC_REGS_VH
// register byte offsets
`define ADCOC_CTRL_ADDR      8'h00
`define ADCOC_STAT_ADDR      8'h04
`define ADCOC_CNT_ADDR       8'h08
// control field positions
`define ADCOC_CTRL_PDSEL     0
`define ADCOC_CTRL_OEN       1
`define ADCOC_CTRL_SAMPEN    2
`define ADCOC_CTRL_RST       3'h2
// strap codes
`define ADCOC_MODE_GND       2'h0
`define ADCOC_MODE_THIRD     2'h1
`define ADCOC_MODE_TWOTHIRD  2'h2
`define ADCOC_MODE_VDD       2'h3
// output codes
`define ADCOC_CODE_MID       10'h200
`define ADCOC_CODE_TOP       10'h3FF
`define ADCOC_CODE_BOT       10'h000
// timing
`define ADCOC_CLK_MHZ        100
`define ADCOC_RELOCK_CYC     100
`define ADCOC_NAP_CYC        100
`define ADCOC_SLEEP_MS       2
`define ADCOC_SLEEP_CYC      (`ADCOC_SLEEP_MS * 1000 * `ADCOC_CLK_MHZ)
`define ADCOC_PIPE_LAT       5
// power states
`define ADCOC_PS_RUN         2'h0
`define ADCOC_PS_NAP         2'h1
`define ADCOC_PS_SLEEP       2'h2
`define ADCOC_PS_WAKE        2'h3
`endif

/* dv/adcoc_chk.sv */
// port checker for adcoc_top
// bound to the design from the bench top file, one clock domain
`timescale 1ns/1ps
module adcoc_chk (
  // clock, reset, bus
  input wire       ref_clk,
  input wire       sys_rst,
  input wire       clk_en,
  input wire       wb_cyc_i,
  input wire       wb_stb_i,
  input wire       wb_ack_o,
  // pins and outputs
  input wire       power_down_pin,
  input wire       out_ctrl_n_pin,
  input wire       sample_strobe,
  input wire [9:0] sample_word_o,
  input wire [9:0] sample_word_oe_n,
  input wire       overrange_flag_o,
  input wire       overrange_flag_oe_n,
  input wire       data_valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // bus answers one edge after a request, for one cycle only
  a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    && clk_en |=> wb_ack_o) else $error("ack missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  // flag only with a clamped end code
  a_flag_clamps: assert property (overrange_flag_o |->
    sample_word_o[8:0] inside {9'h000, 9'h1FF}) else $error("no clamp");
  // data and flag float together
  a_oe_together: assert property (
    {overrange_flag_oe_n, sample_word_oe_n} inside {11'h000, 11'h7FF})
    else $error("split float");
  a_pin_floats: assert property (out_ctrl_n_pin [*6] |->
    overrange_flag_oe_n && &sample_word_oe_n) else $error("pin float");
  a_pd_floats: assert property (power_down_pin [*6] |->
    overrange_flag_oe_n && !data_valid) else $error("power float");
  // outputs move only behind a sample strobe
  a_word_holds: assert property (!$past(sample_strobe) &&
    !$past(sample_strobe, 2) && !$past(sample_strobe, 3)
    |-> $stable(sample_word_o)) else $error("word moved");
  a_flag_holds: assert property ($changed(overrange_flag_o) |->
    $past(sample_strobe) || $past(sample_strobe, 2)
    || $past(sample_strobe, 3)) else $error("flag moved");
endmodule

/* dv/adcoc_latch.sv */
// capture latch model standing on the parallel word
// released lines show the inverse of the last captured value
`timescale 1ns/1ps
module adcoc_latch (
  // pins
  input wire         ref_clk,
  input wire [9:0]   pin_word,
  input wire [9:0]   pin_oe_n,
  input wire         pin_flag,
  input wire         flag_oe_n,
  // captured flag and word
  output logic [10:0] held_q = 11'h000
);
  // closes every edge; a floated bit toggles so it never looks valid
  always @(posedge ref_clk)
    held_q <= {flag_oe_n ? ~held_q[10] : pin_flag,
               (pin_oe_n & ~held_q[9:0]) | (~pin_oe_n & pin_word)};
endmodule

/* dv/adc_output_and_power_control_test.sv */
// bench for adcoc_top: wishbone tasks, sample pushes, pin checks
// assumes checker and capture latch compiled first
`timescale 1ns/1ps
module adc_output_and_power_control_test;
  logic ref_clk = 0, sys_rst = 1, clk_en = 1, ext_clk_present = 1;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [1:0] mode_strap = 2'h0;
  logic power_down_pin = 0, out_ctrl_n_pin = 0, sample_strobe = 0;
  logic code_over = 0, code_under = 0, overrange_flag_o;
  logic overrange_flag_oe_n, data_valid, sample_track;
  logic [9:0] sample_code = 10'h000, sample_word_o, sample_word_oe_n;
  logic [10:0] held_q;
  logic [9:0] codes [4] = '{10'h200, 10'h123, 10'h155, 10'h155};
  logic [9:0] exps [4] = '{10'h200, 10'h3FF, 10'h000, 10'h155};
  int mismatches = 0, samples_checked = 0, m, k;
  adcoc_top #(.SLEEP_CYC(50)) u_adcoc_top (.ref_clk, .sys_rst, .clk_en,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .mode_strap, .power_down_pin, .out_ctrl_n_pin,
    .sample_strobe, .sample_code, .code_over, .code_under,
    .ext_clk_present, .sample_word_o, .sample_word_oe_n, .overrange_flag_o,
    .overrange_flag_oe_n, .sample_track, .data_valid);
  adcoc_latch u_adcoc_latch (.ref_clk, .pin_word(sample_word_o),
    .pin_oe_n(sample_word_oe_n), .pin_flag(overrange_flag_o),
    .flag_oe_n(overrange_flag_oe_n), .held_q);
  initial forever #5 ref_clk = ~ref_clk;
  // compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // one classic cycle, held until ack is seen
  task automatic bus(input logic w, input logic [7:0] a, input int d);
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  // eight strobes at half rate, then settle
  task automatic push(input logic [9:0] c, input logic o, input logic u);
    repeat (8) begin
      @(posedge ref_clk);
      {sample_strobe, sample_code, code_over, code_under} <= {1'b1, c, o, u};
      @(posedge ref_clk);
      sample_strobe <= 0;
    end
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    report_and_stop;
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 0;
    bus(0, 8'h00, 0);
    chk(rd, 32'h2);
    chk(sample_word_oe_n, 10'h3FF);
    bus(1, 8'h00, 32'h4);
    repeat (6) @(posedge ref_clk);
    chk(sample_word_oe_n, 10'h000);
    for (m = 0; m < 4; m++) begin
      mode_strap <= 2'(m);
      repeat (4) @(posedge ref_clk);
      bus(0, 8'h04, 0);
      chk(rd[6:5], {m == 1 || m == 2, m >= 2});
    end
    $display("strap test done");
    for (m = 0; m < 2; m++) begin
      mode_strap <= m ? 2'h3 : 2'h0;
      repeat (4) @(posedge ref_clk);
      for (k = 0; k < 4; k++) begin
        push(codes[k], k == 1, k == 2);
        chk(held_q, {k == 1 || k == 2, exps[k] ^ {m[0], 9'h0}});
        chk(sample_track, 1'b1);
      end
    end
    $display("format test done");
    for (m = 0; m < 2; m++) begin
      {out_ctrl_n_pin, power_down_pin} <= {m[0] == 1'b0, 1'b1};
      repeat (8) @(posedge ref_clk);
      bus(0, 8'h04, 0);
      chk(rd[1:0], m ? 2'h1 : 2'h2);
      chk(rd[2], 1'b0);
      chk({overrange_flag_oe_n, sample_word_oe_n}, 11'h7FF);
      {out_ctrl_n_pin, power_down_pin} <= 2'b00;
      repeat (6) @(posedge ref_clk);
      bus(0, 8'h04, 0);
      chk(rd[1:0], 2'h3);
      repeat (110) @(posedge ref_clk);
      bus(0, 8'h04, 0);
      chk(rd[2:0], 3'h4);
      push(10'h2AA, 0, 0);
      // strap still selects twos complement here
      chk(held_q, {1'b0, 10'h0AA});
    end
    // stabilizer on: clock loss, then relock after a hundred strobes
    mode_strap <= 2'h1;
    ext_clk_present <= 0;
    repeat (4) @(posedge ref_clk);
    ext_clk_present <= 1;
    repeat (4) @(posedge ref_clk);
    for (k = 0; k < 12; k++) push(10'h200, 0, 0);
    bus(0, 8'h04, 0);
    chk(rd[7], 1'b0);
    push(10'h200, 0, 0);
    bus(0, 8'h04, 0);
    chk(rd[7], 1'b1);
    $display("relock test done");
    bus(0, 8'h0C, 0);
    chk(rd, 32'h0);
    $display("power and bus test done");
    report_and_stop;
  end
endmodule
bind adcoc_top adcoc_chk u_adcoc_chk (.ref_clk, .sys_rst, .clk_en,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .power_down_pin, .out_ctrl_n_pin,
  .sample_strobe, .sample_word_o, .sample_word_oe_n, .overrange_flag_o,
  .overrange_flag_oe_n, .data_valid);
